/* File: include/aiu_pkg.sv */
// shared constants and types for the add-immediate / add-file datapath
package aiu_pkg;

    // =====================================================================
    // opcode fields
    // =====================================================================
    localparam logic [7:0]  ADD_IMM_OPC     = 8'h0f;
    localparam logic [5:0]  ADD_FILE_OPC    = 6'h09;
    localparam int          OPC_HI_POS      = 8;
    localparam int          FILE_OPC_POS    = 10;
    localparam int          DEST_BIT_POS    = 9;
    localparam int          ACC_BIT_POS     = 8;

    // =====================================================================
    // addressing
    // =====================================================================
    localparam logic [7:0]  INDEXED_LIMIT   = 8'h5f;
    localparam logic [7:0]  ACCESS_SPLIT    = 8'h80;
    localparam logic [3:0]  ACCESS_HI_BANK  = 4'hf;
    localparam logic [3:0]  ACCESS_LO_BANK  = 4'h0;
    localparam logic [7:0]  ACCUM_RESET     = 8'h00;

    // =====================================================================
    // status flag positions
    // =====================================================================
    localparam int          FLAG_CARRY      = 0;
    localparam int          FLAG_DIGIT      = 1;
    localparam int          FLAG_ZERO       = 2;
    localparam int          FLAG_FAULT      = 3;
    localparam int          FLAG_NEG        = 4;

    // four phases of one instruction cycle, gray along the path
    typedef enum logic [1:0] {
        AIU_PH_DECODE = 2'b00,
        AIU_PH_READ   = 2'b01,
        AIU_PH_CALC   = 2'b11,
        AIU_PH_WRITE  = 2'b10
    } aiu_phase_t;

    typedef enum logic [1:0] {
        AIU_OP_NONE = 2'b00,
        AIU_OP_IMM  = 2'b01,
        AIU_OP_FILE = 2'b10
    } aiu_op_t;

    // data memory request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } aiu_mem_req_t;

    typedef struct packed {
        logic neg;
        logic fault;
        logic zero;
        logic digit;
        logic carry;
    } aiu_flags_t;

endpackage : aiu_pkg

/* File: rtl/aiu_adder.sv */
// 8-bit adder with status flag generation
`timescale 1ns/1ps
module aiu_adder (
    input  wire logic [7:0]        i_a,
    input  wire logic [7:0]        i_b,
    output logic      [7:0]        o_sum,
    output aiu_pkg::aiu_flags_t    o_flags
);
    logic [4:0] low_nib;
    logic [8:0] full;

    always_comb begin
        low_nib         = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
        full            = {1'b0, i_a} + {1'b0, i_b};
        o_sum           = full[7:0];
        o_flags.carry   = full[8];
        o_flags.digit   = low_nib[4];
        o_flags.zero    = (full[7:0] == 8'h00);
        o_flags.neg     = full[7];
        o_flags.fault   = (i_a[7] == i_b[7]) && (full[7] != i_a[7]);
    end

endmodule : aiu_adder

/* File: rtl/aiu_core.sv */
// four-phase datapath for the add-immediate and add-to-file instructions
// Functional notes
// RULE1: add_immediate_to_accum (0000 1111 kkkk kkkk) adds the literal to the accumulator and sets all five flags.
// RULE2: add_accum_to_file_reg (0010 01da ffff ffff) adds the accumulator to the data byte and sets all five flags.
// RULE3: destination bit clear writes the sum to the accumulator, set writes it back to the data byte.
// RULE4: access bit clear resolves the address in the fixed access bank, ignoring the bank select register.
// RULE5: access bit set uses the bank_select_register to pick the general_purpose_register bank.
// RULE6: extended set enabled, access bit clear and address at most 5Fh selects indexed literal-offset addressing.
// RULE7: each instruction takes one four-phase cycle: decode, operand read, arithmetic, writeback.
`timescale 1ns/1ps
module aiu_core (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_rstn,
    input  wire logic                  i_instr_valid,
    input  wire logic [15:0]           i_instr,
    input  wire logic [3:0]            i_bank_select_register,
    input  wire logic                  i_ext_set_en,
    input  wire logic [11:0]           i_index_base,
    input  wire logic [7:0]            i_mem_rdata,
    output aiu_pkg::aiu_mem_req_t      o_mem,
    output logic                       o_instr_ready,
    output logic                       o_done,
    output logic                       o_unsupported,
    output logic [7:0]                 o_accum,
    output aiu_pkg::aiu_flags_t        o_flags
);
    // =====================================================================
    // state
    // =====================================================================
    aiu_pkg::aiu_phase_t    phase_reg,   phase_next;
    aiu_pkg::aiu_op_t       op_reg,      op_next;
    logic [15:0]            instr_reg,   instr_next;
    logic [7:0]             operand_reg, operand_next;
    logic [7:0]             sum_reg,     sum_next;
    logic [11:0]            addr_reg,    addr_next;
    logic [7:0]             accum_reg,   accum_next;
    aiu_pkg::aiu_flags_t    flags_reg,   flags_next;
    aiu_pkg::aiu_flags_t    calc_flags;
    aiu_pkg::aiu_mem_req_t  mem_reg,     mem_next;
    logic                   done_reg,    done_next;
    logic                   unsup_reg,   unsup_next;
    logic [7:0]             calc_sum;
    logic [7:0]             faddr;
    logic                   dest_bit;
    logic                   acc_bit;

    assign faddr    = instr_reg[7:0];
    assign dest_bit = instr_reg[aiu_pkg::DEST_BIT_POS];
    assign acc_bit  = instr_reg[aiu_pkg::ACC_BIT_POS];

    aiu_adder aiu_adder_inst (
        .i_a     (accum_reg),
        .i_b     (operand_reg),
        .o_sum   (calc_sum),
        .o_flags (calc_flags)
    );

    // =====================================================================
    // next-state logic
    // =====================================================================
    always_comb begin
        phase_next   = phase_reg;
        op_next      = op_reg;
        instr_next   = instr_reg;
        operand_next = operand_reg;
        sum_next     = sum_reg;
        addr_next    = addr_reg;
        accum_next   = accum_reg;
        flags_next   = flags_reg;
        mem_next     = '0;
        done_next    = 1'b0;
        unsup_next   = 1'b0;
        unique case (phase_reg)
            aiu_pkg::AIU_PH_DECODE: begin
                if (i_instr_valid) begin
                    instr_next = i_instr;
                    if (i_instr[15:aiu_pkg::OPC_HI_POS] == aiu_pkg::ADD_IMM_OPC) begin
                        op_next    = aiu_pkg::AIU_OP_IMM; // RULE1
                        phase_next = aiu_pkg::AIU_PH_READ; // RULE7
                    end else if (i_instr[15:aiu_pkg::FILE_OPC_POS] == aiu_pkg::ADD_FILE_OPC) begin
                        op_next    = aiu_pkg::AIU_OP_FILE; // RULE2
                        phase_next = aiu_pkg::AIU_PH_READ;
                    end else begin
                        op_next    = aiu_pkg::AIU_OP_NONE;
                        unsup_next = 1'b1;
                    end
                end
            end
            aiu_pkg::AIU_PH_READ: begin
                if (op_reg == aiu_pkg::AIU_OP_IMM) begin
                    operand_next = faddr; // RULE1
                end else begin
                    if (i_ext_set_en && !acc_bit && faddr <= aiu_pkg::INDEXED_LIMIT) begin
                        addr_next = i_index_base + {4'h0, faddr}; // RULE6
                    end else if (!acc_bit) begin
                        addr_next = {(faddr < aiu_pkg::ACCESS_SPLIT) ? aiu_pkg::ACCESS_LO_BANK
                                                                     : aiu_pkg::ACCESS_HI_BANK, faddr}; // RULE4
                    end else begin
                        addr_next = {i_bank_select_register, faddr}; // RULE5
                    end
                    mem_next.rd   = 1'b1;
                    mem_next.addr = addr_next; // RULE2
                end
                phase_next = aiu_pkg::AIU_PH_CALC;
            end
            aiu_pkg::AIU_PH_CALC: begin
                if (op_reg == aiu_pkg::AIU_OP_FILE) begin
                    operand_next = i_mem_rdata; // RULE2
                end
                phase_next = aiu_pkg::AIU_PH_WRITE;
            end
            aiu_pkg::AIU_PH_WRITE: begin
                sum_next   = calc_sum;
                flags_next = calc_flags; // RULE1 RULE2
                if (op_reg == aiu_pkg::AIU_OP_FILE && dest_bit) begin
                    mem_next.wr    = 1'b1; // RULE3
                    mem_next.addr  = addr_reg;
                    mem_next.wdata = calc_sum;
                end else begin
                    accum_next = calc_sum; // RULE3
                end
                done_next  = 1'b1;
                phase_next = aiu_pkg::AIU_PH_DECODE; // RULE7
            end
        endcase
    end

    // =====================================================================
    // registers
    // =====================================================================
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            phase_reg   <= aiu_pkg::AIU_PH_DECODE;
            op_reg      <= aiu_pkg::AIU_OP_NONE;
            instr_reg   <= 16'h0000;
            operand_reg <= 8'h00;
            sum_reg     <= 8'h00;
            addr_reg    <= 12'h000;
            accum_reg   <= aiu_pkg::ACCUM_RESET;
            flags_reg   <= '0;
            mem_reg     <= '0;
            done_reg    <= 1'b0;
            unsup_reg   <= 1'b0;
        end else begin
            phase_reg   <= phase_next;
            op_reg      <= op_next;
            instr_reg   <= instr_next;
            operand_reg <= operand_next;
            sum_reg     <= sum_next;
            addr_reg    <= addr_next;
            accum_reg   <= accum_next;
            flags_reg   <= flags_next;
            mem_reg     <= mem_next;
            done_reg    <= done_next;
            unsup_reg   <= unsup_next;
        end
    end

    assign o_mem         = mem_reg;
    assign o_instr_ready = (phase_reg == aiu_pkg::AIU_PH_DECODE);
    assign o_done        = done_reg;
    assign o_unsupported = unsup_reg;
    assign o_accum       = accum_reg;
    assign o_flags       = flags_reg;

    // =====================================================================
    // assertions
    // =====================================================================
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    imm_sum_a: assert property ( // RULE1
        (phase_reg == aiu_pkg::AIU_PH_DECODE && i_instr_valid
         && i_instr[15:8] == aiu_pkg::ADD_IMM_OPC)
        |-> ##4 (accum_reg == 8'($past(accum_reg, 4) + $past(i_instr[7:0], 4))) && done_reg)
        else $error("immediate add result wrong");

    file_read_a: assert property ( // RULE2
        (phase_reg == aiu_pkg::AIU_PH_DECODE && i_instr_valid
         && i_instr[15:10] == aiu_pkg::ADD_FILE_OPC) |-> ##2 mem_reg.rd)
        else $error("file operand not read");

    dest_mem_a: assert property ( // RULE3
        done_next && op_reg == aiu_pkg::AIU_OP_FILE && dest_bit
        |=> mem_reg.wr && mem_reg.wdata == sum_reg && $stable(accum_reg))
        else $error("memory writeback missing");

    dest_accum_a: assert property ( // RULE3
        done_next && op_reg == aiu_pkg::AIU_OP_FILE && !dest_bit
        |=> !mem_reg.wr && accum_reg == sum_reg)
        else $error("accumulator writeback missing");

    access_bank_a: assert property ( // RULE4
        mem_reg.rd && !acc_bit && !($past(i_ext_set_en) && faddr <= aiu_pkg::INDEXED_LIMIT)
        |-> mem_reg.addr[7:0] == faddr
            && mem_reg.addr[11:8] == (faddr[7] ? 4'hf : 4'h0))
        else $error("access bank address wrong");

    banked_a: assert property ( // RULE5
        mem_reg.rd && acc_bit |-> mem_reg.addr == {$past(i_bank_select_register), faddr})
        else $error("banked address wrong");

    indexed_a: assert property ( // RULE6
        mem_reg.rd && !acc_bit && $past(i_ext_set_en) && faddr <= aiu_pkg::INDEXED_LIMIT
        |-> mem_reg.addr == 12'($past(i_index_base) + {4'h0, faddr}))
        else $error("indexed address wrong");

    four_phase_a: assert property ( // RULE7
        phase_reg == aiu_pkg::AIU_PH_READ
        |=> phase_reg == aiu_pkg::AIU_PH_CALC ##1 phase_reg == aiu_pkg::AIU_PH_WRITE
            ##1 phase_reg == aiu_pkg::AIU_PH_DECODE && done_reg)
        else $error("phase sequence broken");

    zero_flag_a: assert property ( // RULE1
        done_reg |-> flags_reg.zero == (sum_reg == 8'h00) && flags_reg.neg == sum_reg[7])
        else $error("zero or negative flag wrong");

    imm_cov: cover property (done_reg && op_reg == aiu_pkg::AIU_OP_IMM);
    file_mem_cov: cover property (mem_reg.wr);
    idx_cov: cover property (mem_reg.rd && i_ext_set_en && !acc_bit);
    carry_cov: cover property (done_reg && flags_reg.carry && flags_reg.fault);

endmodule : aiu_core

/* File: tb/tb_aiu_core.sv */
// self-checking bench for the add-immediate / add-to-file datapath
`timescale 1ns/1ps
module tb_aiu_core;
    logic                  i_sys_clk = 1'b0;
    logic                  i_rstn = 1'b0;
    logic                  i_instr_valid = 1'b0;
    logic [15:0]           i_instr = 16'h0000;
    logic [3:0]            i_bank_select_register = 4'h0;
    logic                  i_ext_set_en = 1'b0;
    logic [11:0]           i_index_base = 12'h000;
    logic [7:0]            i_mem_rdata = 8'h00;
    aiu_pkg::aiu_mem_req_t o_mem;
    logic                  o_instr_ready;
    logic                  o_done;
    logic                  o_unsupported;
    logic [7:0]            o_accum;
    aiu_pkg::aiu_flags_t   o_flags;
    int                    fails = 0;
    int                    n_compared = 0;
    int                    cyc;
    int                    rd_cyc;
    logic [7:0]            acc_exp;
    logic                  rd_seen;
    logic                  wr_seen;
    logic                  unsup_seen;
    logic [11:0]           rd_addr;
    logic [11:0]           wr_addr;
    logic [7:0]            wdata;

    always #25 i_sys_clk = ~i_sys_clk;

    aiu_core aiu_core_inst (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_instr_valid(i_instr_valid),
        .i_instr(i_instr), .i_bank_select_register(i_bank_select_register), .i_ext_set_en(i_ext_set_en),
        .i_index_base(i_index_base), .i_mem_rdata(i_mem_rdata), .o_mem(o_mem), .o_instr_ready(o_instr_ready),
        .o_done(o_done), .o_unsupported(o_unsupported), .o_accum(o_accum), .o_flags(o_flags));

    task automatic cmp_val(input string name, input logic [11:0] exp, input logic [11:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_val

    task automatic cmp_flags(input string name, input aiu_pkg::aiu_flags_t exp, input aiu_pkg::aiu_flags_t got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask : cmp_flags

    function automatic aiu_pkg::aiu_flags_t flags_of(input logic [7:0] a, input logic [7:0] b);
        logic [8:0]          s;
        logic [4:0]          h;
        aiu_pkg::aiu_flags_t f;
        s = {1'b0, a} + {1'b0, b};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        f.carry = s[8];
        f.digit = h[4];
        f.zero  = (s[7:0] == 8'h00);
        f.neg   = s[7];
        f.fault = (a[7] == b[7]) && (s[7] != a[7]);
        return f;
    endfunction : flags_of

    // offer one word, then follow it; read data is valid only in cycle 2
    task automatic run(input logic [15:0] w, input logic [7:0] m);
        @(posedge i_sys_clk);
        i_instr_valid <= 1'b1;
        i_instr       <= w;
        @(posedge i_sys_clk);
        i_instr_valid <= 1'b0;
        i_instr       <= ~w;
        #1;
        // cycle 1 is the one right after the taking edge
        cyc = 1;
        rd_cyc = 0;
        {rd_seen, wr_seen, unsup_seen} = 3'h0;
        unsup_seen = (o_unsupported === 1'b1);
        while (cyc < 8 && o_done !== 1'b1 && !unsup_seen) begin
            @(posedge i_sys_clk);
            cyc++;
            i_mem_rdata <= (cyc == 2) ? m : ~m;
            #1;
            if (o_mem.rd === 1'b1) begin
                rd_seen = 1'b1;
                rd_cyc  = cyc;
                rd_addr = o_mem.addr;
            end
            if (o_mem.wr === 1'b1) begin
                wr_seen = 1'b1;
                wr_addr = o_mem.addr;
                wdata   = o_mem.wdata;
            end
            unsup_seen = (o_unsupported === 1'b1);
            if (o_done !== 1'b1 && !unsup_seen) cmp_val("ready busy", 12'h000, 12'(o_instr_ready));
        end
    endtask : run

    task automatic add_imm(input logic [7:0] k);
        aiu_pkg::aiu_flags_t f;
        f = flags_of(acc_exp, k);
        acc_exp = acc_exp + k;
        run({aiu_pkg::ADD_IMM_OPC, k}, 8'h00);
        cmp_val("imm cycles", 12'h004, 12'(cyc));
        cmp_val("imm ready", 12'h001, 12'(o_instr_ready));
        cmp_val("imm accum", 12'(acc_exp), 12'(o_accum));
        cmp_flags("imm flags", f, o_flags);
        cmp_val("imm mem", 12'h000, 12'({rd_seen, wr_seen}));
    endtask : add_imm

    task automatic add_file(input logic d, input logic a, input logic ext, input logic [3:0] bank_select_register,
                            input logic [11:0] base, input logic [7:0] f, input logic [7:0] m,
                            input logic [11:0] exp_addr);
        aiu_pkg::aiu_flags_t fl;
        logic [7:0]          s;
        fl = flags_of(acc_exp, m);
        s = acc_exp + m;
        if (!d) acc_exp = s;
        @(posedge i_sys_clk);
        i_bank_select_register <= bank_select_register;
        i_ext_set_en           <= ext;
        i_index_base           <= base;
        run({aiu_pkg::ADD_FILE_OPC, d, a, f}, m);
        cmp_val("file cycles", 12'h004, 12'(cyc));
        cmp_val("read cycle", 12'h002, 12'(rd_cyc));
        cmp_val("read addr", exp_addr, rd_addr);
        cmp_val("write seen", 12'(d), 12'(wr_seen));
        if (d) cmp_val("write addr", exp_addr, wr_addr);
        if (d) cmp_val("write data", 12'(s), 12'(wdata));
        cmp_val("file accum", 12'(acc_exp), 12'(o_accum));
        cmp_flags("file flags", fl, o_flags);
    endtask : add_file

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    initial begin
        #100000;
        fails++;
        test_done();
    end

    initial begin
        acc_exp = aiu_pkg::ACCUM_RESET;
        repeat (5) @(posedge i_sys_clk);
        #1;
        cmp_val("reset accum", 12'h000, 12'(o_accum));
        cmp_flags("reset flags", 5'h00, o_flags);
        cmp_val("reset ready", 12'h001, 12'(o_instr_ready));
        @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        $display("test reset done");
        add_imm(8'h10);
        add_imm(8'h15);
        add_imm(8'hdb);
        add_imm(8'h7f);
        add_imm(8'h01);
        $display("test immediate done");
        add_file(1'b0, 1'b1, 1'b0, 4'h3, 12'h000, 8'hc2, 8'h17, 12'h3c2);
        add_file(1'b1, 1'b1, 1'b0, 4'h5, 12'h000, 8'h20, 8'h01, 12'h520);
        add_file(1'b1, 1'b0, 1'b0, 4'h7, 12'h100, 8'h10, 8'h70, 12'h010);
        add_file(1'b1, 1'b0, 1'b1, 4'h7, 12'h100, 8'h90, 8'h69, 12'hf90);
        add_file(1'b1, 1'b0, 1'b1, 4'h7, 12'h100, 8'h5f, 8'h80, 12'h15f);
        add_file(1'b1, 1'b0, 1'b1, 4'h7, 12'h100, 8'h60, 8'hff, 12'h060);
        add_file(1'b1, 1'b1, 1'b1, 4'h2, 12'h100, 8'h10, 8'h00, 12'h210);
        $display("test file done");
        run(16'h0e55, 8'h00);
        cmp_val("unsup pulse", 12'h001, 12'(unsup_seen));
        cmp_val("unsup cycle", 12'h001, 12'(cyc));
        repeat (4) begin
            @(posedge i_sys_clk);
            #1;
            cmp_val("unsup done", 12'h000, 12'(o_done));
        end
        cmp_val("unsup accum", 12'(acc_exp), 12'(o_accum));
        $display("test unsupported done");
        test_done();
    end
endmodule : tb_aiu_core
